// ===== atq_meas_if.sv
// Signals between the trigger controller and its duration counter.
// Assumes both ends run on the same timebase clock.
interface atq_meas_if #(parameter int TW = 28);
	logic clr;
	logic run;
	logic up_en;
	logic lo_en;
	logic [TW-1:0] up_lim;
	logic [TW-1:0] lo_lim;
	logic [TW-1:0] count;
	logic pass;
	logic at_up;
	modport ctrl(output clr, run, up_en, lo_en, up_lim, lo_lim,
		input count, pass, at_up);
	modport meas(input clr, run, up_en, lo_en, up_lim, lo_lim,
		output count, pass, at_up);
endinterface

// ===== atq_pkg.sv
// Register map, field positions, reset values, timing counts and types of
// the advanced trigger qualifier.
// Assumes one 10 MHz timebase clock; every time limit is a count of it.
package atq_pkg;
	localparam int ATQ_NSRC = 5;
	localparam int ATQ_TW = 28;
	localparam int ATQ_EW = 30;
	localparam int ATQ_LW = 11;
	localparam logic [7:0] ATQ_CTRL_OFF = 8'h00;
	localparam logic [7:0] ATQ_PAT_OFF = 8'h04;
	localparam logic [7:0] ATQ_UPLIM_OFF = 8'h08;
	localparam logic [7:0] ATQ_LOLIM_OFF = 8'h0c;
	localparam logic [7:0] ATQ_HOLD_OFF = 8'h10;
	localparam logic [7:0] ATQ_QEVT_OFF = 8'h14;
	localparam logic [7:0] ATQ_VID_OFF = 8'h18;
	localparam logic [7:0] ATQ_VCUST_OFF = 8'h1c;
	localparam logic [7:0] ATQ_STAT_OFF = 8'h20;
	localparam int ATQ_MODE_LSB = 0;
	localparam int ATQ_POL_BIT = 3;
	localparam int ATQ_SRC_LSB = 4;
	localparam int ATQ_UPEN_BIT = 7;
	localparam int ATQ_LOEN_BIT = 8;
	localparam int ATQ_ENTER_BIT = 9;
	localparam int ATQ_HOEN_BIT = 10;
	localparam int ATQ_HOEVT_BIT = 11;
	localparam int ATQ_QABOVE_BIT = 12;
	localparam int ATQ_QSRC_LSB = 13;
	localparam int ATQ_QKIND_LSB = 16;
	localparam int ATQ_VCUST_BIT = 18;
	localparam int ATQ_V525_BIT = 19;
	localparam int ATQ_LINE_LSB = 0;
	localparam int ATQ_FIELD_LSB = 12;
	localparam int ATQ_NFLD_LSB = 16;
	localparam int ATQ_VLINES_LSB = 0;
	localparam int ATQ_VRATE_LSB = 12;
	localparam int ATQ_VILACE_LSB = 20;
	localparam int ATQ_QVAL_BIT = 0;
	localparam int ATQ_HOACT_BIT = 1;
	localparam int ATQ_FCNT_LSB = 2;
	localparam int ATQ_TCNT_LSB = 16;
	localparam logic [1:0] ATQ_TERM_LOW = 2'h1;
	localparam logic [1:0] ATQ_TERM_HIGH = 2'h2;
	localparam logic [31:0] ATQ_CTRL_RST = 32'h0;
	localparam logic [31:0] ATQ_PAT_RST = 32'h0;
	localparam logic [31:0] ATQ_LIM_RST = 32'h1;
	localparam logic [31:0] ATQ_CNT_RST = 32'h1;
	localparam logic [31:0] ATQ_VID_RST = 32'h1;
	localparam logic [31:0] ATQ_VCUST_RST = 32'h0023_2271;
	localparam int ATQ_CLK_HZ = 10_000_000;
	localparam int ATQ_CLK_PS = 100_000;
	localparam int ATQ_DROP_MIN_PS = 25_000;
	localparam int ATQ_WIDTH_MIN_PS = 2_500;
	localparam int ATQ_IVAL_MIN_PS = 10_000;
	localparam int ATQ_TIME_MAX_S = 20;
	localparam int ATQ_DROP_MIN_CYC =
		(ATQ_DROP_MIN_PS + ATQ_CLK_PS - 1) / ATQ_CLK_PS;
	localparam int ATQ_WIDTH_MIN_CYC =
		(ATQ_WIDTH_MIN_PS + ATQ_CLK_PS - 1) / ATQ_CLK_PS;
	localparam int ATQ_IVAL_MIN_CYC =
		(ATQ_IVAL_MIN_PS + ATQ_CLK_PS - 1) / ATQ_CLK_PS;
	localparam int ATQ_TIME_MAX_CYC = ATQ_TIME_MAX_S * ATQ_CLK_HZ;
	localparam int ATQ_EVT_MIN = 1;
	localparam int ATQ_EVT_MAX = 1_000_000_000;
	localparam logic [ATQ_LW-1:0] ATQ_LINES_625 = 11'h271;
	localparam logic [ATQ_LW-1:0] ATQ_LINES_525 = 11'h20d;
	typedef enum logic [2:0] {ATQ_OFF, ATQ_DROPOUT, ATQ_GLITCH,
		ATQ_INTERVAL, ATQ_PATTERN, ATQ_VIDEO, ATQ_QUAL} atq_mode_t;
	typedef enum logic [1:0] {ATQ_Q_WITHIN, ATQ_Q_WAIT,
		ATQ_Q_EVENTS} atq_qkind_t;
endpackage

// ===== atq_src_model.sv
// Behavioural stand-in for the channel comparators and the sync separator.
// Assumes its tasks are called just after a rising edge of clk_in.
module atq_src_model import atq_pkg::*; (
	// Clock.
	input wire logic clk_in,
	// Comparator and sync levels.
	output logic [atq_pkg::ATQ_NSRC-1:0] cmp_out,
	output logic line_sync_out,
	output logic field_start_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmp_out = 5'h00;
		line_sync_out = 1'b0;
		field_start_out = 1'b0;
	end
	// Sets every comparator level at once and lets one edge pass.
	task automatic set_all(input logic [4:0] v);
		cmp_out <= v;
		@(posedge clk_in);
	endtask
	// Holds source 0 away from its present level for w cycles.
	// Only source 0 pulses, so pattern cases steer it with the other levels.
	task automatic pulse(input int w);
		cmp_out <= cmp_out ^ 5'h01;
		repeat (w) @(posedge clk_in);
		cmp_out <= cmp_out ^ 5'h01;
		@(posedge clk_in);
	endtask
	// Starts a field, then gives n one-cycle line syncs two cycles apart.
	task automatic field(input int n);
		field_start_out <= 1'b1;
		@(posedge clk_in);
		field_start_out <= 1'b0;
		repeat (n) begin
			@(posedge clk_in);
			line_sync_out <= 1'b1;
			@(posedge clk_in);
			line_sync_out <= 1'b0;
		end
		@(posedge clk_in);
	endtask
endmodule

// ===== atq_top.sv
// Trigger decision logic: dropout, glitch, interval, pattern, video line
// and state-qualified triggers with holdoff, set up over APB.
// Assumes asynchronous comparator and sync inputs and a 10 MHz clock.
//
// Added by the designer: the register addresses and the APB interface to the registers.

module atq_top #(
	parameter int TIME_MAX_CYC = atq_pkg::ATQ_TIME_MAX_CYC
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// APB register port.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Comparator and video sync inputs, asynchronous.
	input wire logic [atq_pkg::ATQ_NSRC-1:0] cmp_in,
	input wire logic line_sync_in,
	input wire logic field_start_in,
	// Trigger and qualifier state.
	output logic trig_out,
	output logic qual_valid_out
);
	import atq_pkg::*;

	logic [31:0] ctrl_reg;
	logic [31:0] pat_reg;
	logic [31:0] vid_reg;
	logic [31:0] vcust_reg;
	logic [ATQ_TW-1:0] uplim_reg;
	logic [ATQ_TW-1:0] lolim_reg;
	logic [ATQ_EW-1:0] hold_reg;
	logic [ATQ_EW-1:0] qevt_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rd_data;
	logic [31:0] stat_word;
	logic setup;
	logic access;
	logic addr_ok;
	logic wr_en;
	logic wr_ctrl;
	atq_mode_t mode;
	atq_qkind_t qkind;
	logic pol;
	logic up_en;
	logic lo_en;
	logic enter;
	logic ho_en;
	logic ho_evt;
	logic qabove;
	logic vcust;
	logic v525;
	logic [2:0] src;
	logic [2:0] qsrc;
	logic [6:0] sy1_reg;
	logic [6:0] sy2_reg;
	logic [6:0] sy3_reg;
	logic [ATQ_NSRC-1:0] term_ok;
	logic pat_now;
	logic pat_prev_reg;
	logic src_pat;
	logic cur;
	logic prv;
	logic edge_a;
	logic edge_b;
	logic q_raw;
	logic q_now;
	logic q_rise;
	logic qvalid_reg;
	logic [ATQ_TW-1:0] min_cyc;
	logic [ATQ_TW-1:0] up_eff;
	logic [ATQ_TW-1:0] lo_eff;
	logic armed_reg;
	logic [ATQ_TW-1:0] qt;
	logic [ATQ_EW-1:0] qev_base;
	logic [ATQ_EW-1:0] qev_cnt_reg;
	logic q_ev;
	logic q_ok;
	logic v_ft;
	logic v_lt;
	logic [ATQ_LW-1:0] lines_pic;
	logic [ATQ_LW-1:0] line_cnt_reg;
	logic [ATQ_LW-1:0] line_next;
	logic [2:0] fcnt_reg;
	logic c_drop;
	logic c_glitch;
	logic c_ival;
	logic c_pat;
	logic c_video;
	logic c_qual;
	logic cand;
	logic fire;
	logic ho_act;
	logic [ATQ_EW-1:0] ho_cnt_reg;
	logic [ATQ_EW-1:0] ho_load;
	logic trig_reg;
	logic [15:0] trig_cnt_reg;

	atq_meas_if #(.TW(ATQ_TW)) mif ();

	function automatic logic [31:0] clamp(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] r;
		r = v;
		if (r > hi) begin
			r = hi;
		end
		if (r < lo) begin
			r = lo;
		end
		return r;
	endfunction

	assign mode = atq_mode_t'(ctrl_reg[ATQ_MODE_LSB +: 3]);
	assign qkind = atq_qkind_t'(ctrl_reg[ATQ_QKIND_LSB +: 2]);
	assign pol = ctrl_reg[ATQ_POL_BIT];
	assign up_en = ctrl_reg[ATQ_UPEN_BIT];
	assign lo_en = ctrl_reg[ATQ_LOEN_BIT];
	assign enter = ctrl_reg[ATQ_ENTER_BIT];
	assign ho_en = ctrl_reg[ATQ_HOEN_BIT];
	assign ho_evt = ctrl_reg[ATQ_HOEVT_BIT];
	assign qabove = ctrl_reg[ATQ_QABOVE_BIT];
	assign vcust = ctrl_reg[ATQ_VCUST_BIT];
	assign v525 = ctrl_reg[ATQ_V525_BIT];
	assign src = ctrl_reg[ATQ_SRC_LSB +: 3];
	assign qsrc = ctrl_reg[ATQ_QSRC_LSB +: 3];

	// APB slave: one wait-free access phase, unmapped addresses answer error.
	assign setup = psel_in && !penable_in;
	assign access = psel_in && penable_in && pready_reg;
	assign wr_en = access && pwrite_in && addr_ok;
	assign wr_ctrl = wr_en && (paddr_in == ATQ_CTRL_OFF);

	always_comb begin
		stat_word = '0;
		stat_word[ATQ_QVAL_BIT] = qvalid_reg;
		stat_word[ATQ_HOACT_BIT] = ho_act;
		stat_word[ATQ_FCNT_LSB +: 3] = fcnt_reg;
		stat_word[ATQ_TCNT_LSB +: 16] = trig_cnt_reg;
	end

	always_comb begin
		addr_ok = 1'b1;
		case (paddr_in)
			ATQ_CTRL_OFF: rd_data = ctrl_reg;
			ATQ_PAT_OFF: rd_data = pat_reg;
			ATQ_UPLIM_OFF: rd_data = 32'(uplim_reg);
			ATQ_LOLIM_OFF: rd_data = 32'(lolim_reg);
			ATQ_HOLD_OFF: rd_data = 32'(hold_reg);
			ATQ_QEVT_OFF: rd_data = 32'(qevt_reg);
			ATQ_VID_OFF: rd_data = vid_reg;
			ATQ_VCUST_OFF: rd_data = vcust_reg;
			ATQ_STAT_OFF: rd_data = stat_word;
			default: begin
				rd_data = 32'h0;
				addr_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				prdata_reg <= pwrite_in ? 32'h0 : rd_data;
				pslverr_reg <= !addr_ok;
			end
		end
	end

	// Limits are clamped on write so software cannot park a counter
	// beyond what the counters can reach.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= ATQ_CTRL_RST;
			pat_reg <= ATQ_PAT_RST;
			uplim_reg <= ATQ_LIM_RST[ATQ_TW-1:0];
			lolim_reg <= ATQ_LIM_RST[ATQ_TW-1:0];
			hold_reg <= ATQ_CNT_RST[ATQ_EW-1:0];
			qevt_reg <= ATQ_CNT_RST[ATQ_EW-1:0];
			vid_reg <= ATQ_VID_RST;
			vcust_reg <= ATQ_VCUST_RST;
		end else if (wr_en) begin
			case (paddr_in)
				ATQ_CTRL_OFF: ctrl_reg <= pwdata_in;
				ATQ_PAT_OFF: pat_reg <= pwdata_in;
				ATQ_UPLIM_OFF: uplim_reg <= ATQ_TW'(clamp(pwdata_in,
					32'h1, 32'(TIME_MAX_CYC)));
				ATQ_LOLIM_OFF: lolim_reg <= ATQ_TW'(clamp(pwdata_in,
					32'h1, 32'(TIME_MAX_CYC)));
				ATQ_HOLD_OFF: hold_reg <= ATQ_EW'(clamp(pwdata_in,
					32'(ATQ_EVT_MIN), 32'(ATQ_EVT_MAX)));
				ATQ_QEVT_OFF: qevt_reg <= ATQ_EW'(clamp(pwdata_in,
					32'(ATQ_EVT_MIN), 32'(ATQ_EVT_MAX)));
				ATQ_VID_OFF: vid_reg <= pwdata_in;
				ATQ_VCUST_OFF: vcust_reg <= pwdata_in;
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Two flops per pin before any logic; the third only feeds edge tests.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sy1_reg <= 7'h0;
			sy2_reg <= 7'h0;
			sy3_reg <= 7'h0;
		end else begin
			sy1_reg <= {field_start_in, line_sync_in, cmp_in};
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
		end
	end

	generate
		for (genvar i = 0; i < ATQ_NSRC; i++) begin : g_term
			assign term_ok[i] = (pat_reg[2*i +: 2] == ATQ_TERM_LOW) ?
				!sy2_reg[i] : (pat_reg[2*i +: 2] == ATQ_TERM_HIGH) ?
				sy2_reg[i] : 1'b1;
		end
	endgenerate

	assign pat_now = &term_ok;
	assign src_pat = (src >= 3'(ATQ_NSRC));
	assign cur = src_pat ? pat_now : sy2_reg[src];
	assign prv = src_pat ? pat_prev_reg : sy3_reg[src];
	assign edge_a = pol ? (cur && !prv) : (!cur && prv);
	assign edge_b = pol ? (!cur && prv) : (cur && !prv);

	assign q_raw = (qsrc >= 3'(ATQ_NSRC)) ? pat_now : sy2_reg[qsrc];
	assign q_now = qabove ? q_raw : !q_raw;
	assign q_rise = q_now && !qvalid_reg;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pat_prev_reg <= 1'b0;
			qvalid_reg <= 1'b0;
		end else begin
			pat_prev_reg <= pat_now;
			qvalid_reg <= q_now;
		end
	end

	always_comb begin
		case (mode)
			ATQ_DROPOUT: min_cyc = ATQ_TW'(ATQ_DROP_MIN_CYC);
			ATQ_GLITCH: min_cyc = ATQ_TW'(ATQ_WIDTH_MIN_CYC);
			default: min_cyc = ATQ_TW'(ATQ_IVAL_MIN_CYC);
		endcase
	end

	assign up_eff = (uplim_reg < min_cyc) ? min_cyc : uplim_reg;
	assign lo_eff = (lolim_reg < min_cyc) ? min_cyc : lolim_reg;
	assign mif.up_en = up_en;
	assign mif.lo_en = lo_en;
	assign mif.up_lim = up_eff;
	assign mif.lo_lim = lo_eff;

	always_comb begin
		mif.clr = 1'b0;
		mif.run = 1'b1;
		case (mode)
			ATQ_DROPOUT, ATQ_GLITCH, ATQ_INTERVAL: mif.clr = edge_a;
			ATQ_QUAL: begin
				mif.clr = q_rise;
				mif.run = q_now;
			end
			default: mif.run = 1'b0;
		endcase
	end

	atq_window #(.TW(ATQ_TW)) u_win (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.m(mif)
	);

	// A measurement only counts once a starting edge has been seen.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			armed_reg <= 1'b0;
		end else if (wr_ctrl) begin
			armed_reg <= 1'b0;
		end else if (mif.clr && mode != ATQ_QUAL) begin
			armed_reg <= 1'b1;
		end else if (c_drop || (mode == ATQ_GLITCH && edge_b)) begin
			armed_reg <= 1'b0;
		end
	end

	assign c_drop = (mode == ATQ_DROPOUT) && armed_reg && mif.at_up &&
		!edge_a;
	assign c_glitch = (mode == ATQ_GLITCH) && armed_reg && edge_b &&
		mif.pass;
	assign c_ival = (mode == ATQ_INTERVAL) && armed_reg && edge_a &&
		mif.pass;
	assign c_pat = (mode == ATQ_PATTERN) && (enter ?
		(pat_now && !pat_prev_reg) : (!pat_now && pat_prev_reg));

	// Qualified trigger; a new validation sees a fresh timer and count.
	assign qt = q_rise ? '0 : mif.count;
	assign qev_base = q_rise ? '0 : qev_cnt_reg;
	assign q_ev = edge_a && q_now;

	always_comb begin
		case (qkind)
			ATQ_Q_WITHIN: q_ok = (qt < up_eff);
			ATQ_Q_WAIT: q_ok = (qt >= up_eff);
			ATQ_Q_EVENTS: q_ok = (qev_base + 1'b1 == qevt_reg);
			default: q_ok = 1'b0;
		endcase
	end

	assign c_qual = (mode == ATQ_QUAL) && q_ev && q_ok;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			qev_cnt_reg <= '0;
		end else if (!q_now) begin
			qev_cnt_reg <= '0;
		end else if (q_ev && qev_base != '1) begin
			qev_cnt_reg <= qev_base + 1'b1;
		end else if (q_rise) begin
			qev_cnt_reg <= '0;
		end
	end

	// Video: line syncs counted from each field start; fields counted
	// modulo the programmed cycle, so numbering is relative only.
	assign v_ft = sy2_reg[6] && !sy3_reg[6];
	assign v_lt = sy2_reg[5] && !sy3_reg[5];
	assign lines_pic = vcust ? vcust_reg[ATQ_VLINES_LSB +: ATQ_LW] :
		(v525 ? ATQ_LINES_525 : ATQ_LINES_625);
	assign line_next = line_cnt_reg + 1'b1;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fcnt_reg <= 3'h0;
			line_cnt_reg <= '0;
		end else if (v_ft) begin
			fcnt_reg <= (fcnt_reg == vid_reg[ATQ_NFLD_LSB +: 3]) ?
				3'h0 : fcnt_reg + 1'b1;
			line_cnt_reg <= '0;
		end else if (v_lt && line_cnt_reg < lines_pic) begin
			line_cnt_reg <= line_next;
		end
	end

	// Past the last line of a picture the counter stands still, so no
	// later sync may pose as a line beyond the programmed count.
	assign c_video = (mode == ATQ_VIDEO) && v_lt && !v_ft &&
		(line_cnt_reg < lines_pic) &&
		(line_next == vid_reg[ATQ_LINE_LSB +: ATQ_LW]) &&
		(fcnt_reg == vid_reg[ATQ_FIELD_LSB +: 3]);

	// Holdoff counts cycles, or suppressed candidates in event mode.
	assign cand = c_drop || c_glitch || c_ival || c_pat || c_video ||
		c_qual;
	assign ho_act = (ho_cnt_reg != '0);
	assign fire = cand && !ho_act;
	assign ho_load = (ho_evt || hold_reg <= ATQ_EW'(TIME_MAX_CYC)) ?
		hold_reg : ATQ_EW'(TIME_MAX_CYC);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ho_cnt_reg <= '0;
		end else if (fire && ho_en) begin
			ho_cnt_reg <= ho_load;
		end else if (ho_act && (!ho_evt || cand)) begin
			ho_cnt_reg <= ho_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			trig_reg <= 1'b0;
			trig_cnt_reg <= 16'h0;
		end else begin
			trig_reg <= fire;
			if (fire) begin
				trig_cnt_reg <= trig_cnt_reg + 1'b1;
			end
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign trig_out = trig_reg;
	assign qual_valid_out = qvalid_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_dropout_timeout: assert property (
		(mode == ATQ_DROPOUT && armed_reg && mif.at_up && !edge_a &&
		!ho_act) |=> trig_out)
		else $error("Dropout timeout passed without trigger.");
	a_glitch_upper: assert property (
		(mode == ATQ_GLITCH && up_en && !lo_en && trig_out) |->
		$past(mif.count) < $past(up_eff))
		else $error("Upper width test fired on a wide pulse.");
	a_glitch_lower: assert property (
		(mode == ATQ_GLITCH && lo_en && !up_en && trig_out) |->
		$past(mif.count) > $past(lo_eff))
		else $error("Lower width test fired on a narrow pulse.");
	a_glitch_band: assert property (
		(mode == ATQ_GLITCH && up_en && lo_en && up_eff > lo_eff &&
		trig_out) |-> $past(mif.count) < $past(up_eff) &&
		$past(mif.count) > $past(lo_eff))
		else $error("Width band test fired outside the band.");
	a_interval_edge: assert property (
		(mode == ATQ_INTERVAL && trig_out) |->
		$past(edge_a) && $past(armed_reg))
		else $error("Interval trigger without a measuring edge.");
	a_pattern_enter: assert property (
		(mode == ATQ_PATTERN && enter && trig_out) |->
		$past(pat_now) && !$past(pat_prev_reg))
		else $error("Entering trigger without pattern start.");
	a_holdoff_time: assert property (
		(trig_out && ho_en && !ho_evt && mode == $past(mode)) |=>
		!trig_out)
		else $error("Trigger repeated inside time holdoff.");
	a_qual_abandon: assert property (
		(mode == ATQ_QUAL && !q_now) |=> !trig_out)
		else $error("Qualified trigger without valid qualifier.");
	a_qual_restart: assert property (
		(mode == ATQ_QUAL && q_rise && !edge_a) |=>
		mif.count == 1 && qev_cnt_reg == 0)
		else $error("Validation did not restart timer and count.");
	a_video_line: assert property (
		(mode == ATQ_VIDEO && trig_out) |->
		line_cnt_reg == vid_reg[ATQ_LINE_LSB +: ATQ_LW] &&
		fcnt_reg == vid_reg[ATQ_FIELD_LSB +: 3])
		else $error("Video trigger on wrong line or field.");
	a_apb_ready: assert property (
		setup |=> pready_out ##1 !pready_out)
		else $error("APB answer not exactly one access cycle.");

	c_dropout: cover property (mode == ATQ_DROPOUT && trig_out);
	c_glitch_hit: cover property (mode == ATQ_GLITCH && trig_out);
	c_qual_hit: cover property (mode == ATQ_QUAL && trig_out);
	c_video_hit: cover property (mode == ATQ_VIDEO && trig_out);
endmodule

// ===== atq_window.sv
// Duration counter with upper and lower limit tests.
// Assumes clr and run come from logic on the same clock.
module atq_window #(
	parameter int TW = 28
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Measurement port.
	atq_meas_if.meas m
);
	logic [TW-1:0] count_reg;
	logic below;
	logic above;

	// Clearing loads one so the count equals cycles since the clearing edge.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			count_reg <= '0;
		end else if (m.clr) begin
			count_reg <= {{(TW-1){1'b0}}, 1'b1};
		end else if (m.run && count_reg != '1) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	assign m.count = count_reg;
	assign m.at_up = (count_reg == m.up_lim);
	assign below = (count_reg < m.up_lim);
	assign above = (count_reg > m.lo_lim);

	always_comb begin
		if (m.up_en && m.lo_en) begin
			// Reversed limits turn the band into an exclusion window.
			if (m.up_lim > m.lo_lim) begin
				m.pass = below && above;
			end else begin
				m.pass = below || above;
			end
		end else begin
			m.pass = (m.up_en && below) || (m.lo_en && above);
		end
	end
endmodule

// ===== testbench.sv
// Self-checking bench: register checks over APB, then a table of trigger
// cases driven through the comparator model.
// Assumes the design package and the comparator model are compiled first.
module testbench import atq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] cmp;
	logic line_sync;
	logic field_start;
	logic trig;
	logic qual_valid;
	logic [31:0] rdata;
	logic rerr;
	int fail_count = 0;
	int cmp_count = 0;
	// Columns: ctrl, pat, upper, lower, idle levels, width, gap, first
	// trigger window low and high (-1 for none), trigger count (0 unchecked).
	int tbl [0:21][0:9] = '{
		'{'h9, 0, 10, 1, 0, 30, 0, 11, 16, 0},
		'{'h8a, 0, 8, 1, 0, 4, 0, 5, 10, 0},
		'{'h8a, 0, 8, 1, 0, 14, 0, -1, -1, 0},
		'{'h10a, 0, 1, 8, 0, 14, 0, 15, 20, 0},
		'{'h10a, 0, 1, 8, 0, 4, 0, -1, -1, 0},
		'{'h18a, 0, 12, 6, 0, 8, 0, 9, 14, 0},
		'{'h18a, 0, 12, 6, 0, 14, 0, -1, -1, 0},
		'{'h18a, 0, 6, 12, 0, 8, 0, -1, -1, 0},
		'{'h18a, 0, 6, 12, 0, 14, 0, 15, 20, 0},
		'{'h82, 0, 8, 1, 1, 4, 0, 5, 10, 0},
		'{'hda, 2, 8, 1, 0, 4, 0, 5, 10, 0},
		'{'h8b, 0, 10, 1, 0, 2, 2, 6, 11, 0},
		'{'h8b, 0, 10, 1, 0, 2, 12, -1, -1, 0},
		'{'h10b, 0, 1, 10, 0, 2, 12, 16, 21, 0},
		'{'h18b, 0, 12, 6, 0, 2, 5, 9, 14, 0},
		'{'h18b, 0, 6, 12, 0, 2, 5, -1, -1, 0},
		'{'h204, 6, 1, 1, 4, 10, 0, 1, 6, 0},
		'{'h004, 6, 1, 1, 4, 10, 0, 11, 16, 0},
		'{'h204, 6, 1, 1, 6, 10, 0, -1, -1, 0},
		'{'h204, 6, 1, 1, 4, 3, 3, 1, 6, 2},
		'{'he04, 6, 1, 1, 4, 3, 3, 1, 6, 1},
		'{'h604, 6, 1, 1, 4, 3, 3, 1, 6, 1}
	};
	atq_top #(.TIME_MAX_CYC(64)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .cmp_in(cmp),
		.line_sync_in(line_sync), .field_start_in(field_start),
		.trig_out(trig), .qual_valid_out(qual_valid));
	atq_src_model src (.clk_in(clk_in), .cmp_out(cmp),
		.line_sync_out(line_sync), .field_start_out(field_start));
	always #50 clk_in = ~clk_in;
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_in(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h to %h", $time, got,
				lo, hi);
		end
	endtask
	// The request is held until pready is seen high, then released.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic err);
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
		check({31'h0, rerr}, {31'h0, err});
	endtask
	task automatic watch(output int first, output int n);
		first = -1;
		n = 0;
		for (int i = 1; i <= 40; i++) begin
			@(posedge clk_in);
			if (trig !== 1'b0) begin
				if (first < 0) first = i;
				n++;
			end
		end
	endtask
	task automatic run(input int r);
		int at;
		int n;
		apb(1'b1, ATQ_CTRL_OFF, 32'h0);
		apb(1'b1, ATQ_PAT_OFF, tbl[r][1]);
		apb(1'b1, ATQ_UPLIM_OFF, tbl[r][2]);
		apb(1'b1, ATQ_LOLIM_OFF, tbl[r][3]);
		src.set_all(5'(tbl[r][4]));
		repeat (4) @(posedge clk_in);
		apb(1'b1, ATQ_CTRL_OFF, tbl[r][0]);
		fork
			watch(at, n);
			begin
				src.pulse(tbl[r][5]);
				if (tbl[r][6] > 0) begin
					repeat (tbl[r][6]) @(posedge clk_in);
					src.pulse(3);
				end
			end
		join
		check_in(at, tbl[r][7], tbl[r][8]);
		if (tbl[r][9] > 0) check(n, tbl[r][9]);
	endtask
	// Qualifier on source 1, then np pulses on source 0; np of zero runs
	// three video fields of four line syncs each instead.
	task automatic xrun(input int c, input int lim, input int w,
		input int np, input logic dr, input int lo, input int hi,
		input int cnt);
		int at;
		int n;
		apb(1'b1, ATQ_CTRL_OFF, 32'h0);
		apb(1'b1, ATQ_UPLIM_OFF, lim);
		apb(1'b1, ATQ_QEVT_OFF, lim);
		apb(1'b1, ATQ_VCUST_OFF, lim);
		src.set_all(5'h00);
		repeat (4) @(posedge clk_in);
		apb(1'b1, ATQ_CTRL_OFF, c);
		fork
			watch(at, n);
			if (np == 0) begin
				repeat (3) src.field(4);
			end else begin
				src.set_all(5'h02);
				repeat (w) @(posedge clk_in);
				if (dr) src.set_all(5'h00);
				repeat (np) src.pulse(2);
			end
		join
		check_in(at, lo, hi);
		check(n, cnt);
		if (np > 0) check(32'(qual_valid), 32'(!dr));
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(ATQ_CTRL_OFF, ATQ_CTRL_RST, 1'b0);
		rd(ATQ_UPLIM_OFF, ATQ_LIM_RST, 1'b0);
		rd(ATQ_HOLD_OFF, ATQ_CNT_RST, 1'b0);
		rd(ATQ_VID_OFF, ATQ_VID_RST, 1'b0);
		rd(ATQ_VCUST_OFF, ATQ_VCUST_RST, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		apb(1'b1, ATQ_PAT_OFF, 32'h0000_02a9);
		rd(ATQ_PAT_OFF, 32'h0000_02a9, 1'b0);
		apb(1'b1, ATQ_HOLD_OFF, 32'h0000_0008);
		rd(ATQ_HOLD_OFF, 32'h0000_0008, 1'b0);
		apb(1'b1, ATQ_VID_OFF, 32'h0001_1003);
		rd(ATQ_VID_OFF, 32'h0001_1003, 1'b0);
		for (int r = 0; r <= 21; r++) begin
			run(r);
		end
		xrun('h300e, 10, 2, 1, 1'b0, 4, 9, 1);
		xrun('h300e, 10, 12, 1, 1'b0, -1, -1, 0);
		xrun('h1300e, 10, 12, 1, 1'b0, 14, 19, 1);
		xrun('h1300e, 10, 2, 1, 1'b0, -1, -1, 0);
		xrun('h2300e, 3, 2, 3, 1'b0, 10, 15, 1);
		xrun('h1300e, 10, 12, 1, 1'b1, -1, -1, 0);
		xrun('h5, 10, 0, 0, 1'b0, 7, 12, 2);
		xrun('h40005, 2, 0, 0, 1'b0, -1, -1, 0);
		end_of_test();
	end
	// A hung handshake or wait would otherwise stall the run forever.
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		end_of_test();
	end
endmodule
